// [shared/sbc_pkg.sv]
package sbc_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int unsigned CLK_MHZ = 200;

	// Times in microseconds / milliseconds, typical figures
	localparam int unsigned SAMPLE_TXD_US = 25;
	localparam int unsigned LP_MODE_US    = 45;
	localparam int unsigned VOUT_FILT_US  = 25;
	localparam int unsigned LIN_WAKE_US   = 80;
	localparam int unsigned RESET_EXT_MS  = 5;

	// Derived cycle counts
	localparam int unsigned SAMPLE_TXD_CYC = SAMPLE_TXD_US * CLK_MHZ;
	localparam int unsigned LP_MODE_CYC    = LP_MODE_US * CLK_MHZ;
	localparam int unsigned VOUT_FILT_CYC  = VOUT_FILT_US * CLK_MHZ;
	localparam int unsigned LIN_WAKE_CYC   = LIN_WAKE_US * CLK_MHZ;
	localparam int unsigned RESET_EXT_CYC  = RESET_EXT_MS * 1000 * CLK_MHZ;

	// Width of all timers
	localparam int unsigned CNT_W = 24;

	// ==========================================================
	// Operating modes
	// ==========================================================
	typedef enum logic [2:0]
	{
		MODE_SHUTDOWN,
		MODE_RESET,
		MODE_NORMAL,
		MODE_STANDBY,
		MODE_SLEEP,
		MODE_THERMAL
	} sbc_mode_e;

	// LIN transceiver sub-modes
	typedef enum logic [1:0]
	{
		LIN_OFF,
		LIN_WAKEUP,
		LIN_ACTIVE
	} sbc_lin_e;

endpackage

// [core/sbc_sync.sv]
`timescale 1ns/1ps

// Two-flop synchroniser for one asynchronous level
module sbc_sync
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic asyncIn,
	output logic      syncOut
);

	typedef struct packed
	{
		logic meta;
		logic sync;
	} sbc_sync_s;

	sbc_sync_s state_q;
	sbc_sync_s state_d;

	// ==========================================================
	// Next state
	// ==========================================================
	// First flop feeds only the second
	always_comb
	begin
		state_d      = state_q;
		state_d.meta = asyncIn;
		state_d.sync = state_q.meta;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign syncOut = state_q.sync;

endmodule

// [core/sbc_filter.sv]
`timescale 1ns/1ps

// Qualifies a level: output goes high once input held high LEN cycles
module sbc_filter
#(
	parameter int unsigned LEN = 16
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic levelIn,
	output logic      qualified
);

	typedef struct packed
	{
		logic [sbc_pkg::CNT_W-1:0] cnt;
		logic                      hit;
	} sbc_filter_s;

	localparam logic [sbc_pkg::CNT_W-1:0] LAST = sbc_pkg::CNT_W'(LEN - 1);

	sbc_filter_s state_q;
	sbc_filter_s state_d;

	// ==========================================================
	// Counter
	// ==========================================================
	// Any drop of the input restarts the count, so glitches never pass
	always_comb
	begin
		state_d = state_q;
		if (!levelIn)
		begin
			state_d.cnt = '0;
			state_d.hit = 1'b0;
		end
		else if (state_q.cnt >= LAST)
			state_d.hit = 1'b1;
		else
			state_d.cnt = state_q.cnt + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign qualified = state_q.hit;

endmodule

// [core/sbc_mode_ctrl.sv]
`timescale 1ns/1ps

module sbc_mode_ctrl
#(
	parameter int unsigned SAMPLE_TXD_CYC = sbc_pkg::SAMPLE_TXD_CYC,
	parameter int unsigned LP_MODE_CYC    = sbc_pkg::LP_MODE_CYC,
	parameter int unsigned VOUT_FILT_CYC  = sbc_pkg::VOUT_FILT_CYC,
	parameter int unsigned LIN_WAKE_CYC   = sbc_pkg::LIN_WAKE_CYC,
	parameter int unsigned RESET_EXT_CYC  = sbc_pkg::RESET_EXT_CYC
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             enablePin,
	input  wire logic             txDataPin,
	input  wire logic             linBusLow,
	input  wire logic             supplyBelowPorLow,
	input  wire logic             supplyAbovePorHigh,
	input  wire logic             junctionOvertemp,
	input  wire logic             voutBelowReset,
	output logic                  regulatorOn,
	output logic                  systemResetOut_n,
	output logic                  systemResetOe_n,
	output logic                  rxDataOut,
	output logic                  linTxEnable,
	output sbc_pkg::sbc_lin_e     linSubMode,
	output sbc_pkg::sbc_mode_e    modeOut
);

	// Last count of each timer; every timer starts from zero
	localparam logic [sbc_pkg::CNT_W-1:0] SAMPLE_LAST = sbc_pkg::CNT_W'(SAMPLE_TXD_CYC - 1);
	localparam logic [sbc_pkg::CNT_W-1:0] LP_LAST     = sbc_pkg::CNT_W'(LP_MODE_CYC - 1);
	localparam logic [sbc_pkg::CNT_W-1:0] RESET_LAST  = sbc_pkg::CNT_W'(RESET_EXT_CYC - 1);

	// Low-power request sequence inside Normal
	typedef enum logic [1:0]
	{
		REQ_NONE,
		REQ_SAMPLE,
		REQ_STANDBY,
		REQ_SLEEP
	} sbc_req_e;

	// All controller state lives in one register
	typedef struct packed
	{
		sbc_pkg::sbc_mode_e        mode;
		sbc_req_e                  req;
		logic [sbc_pkg::CNT_W-1:0] timer;
		logic                      wakePending;
		logic                      enPrev;
		logic                      txBlocked;
		logic                      regOn;
		logic                      rstLow;
		logic                      rxd;
		logic                      txEn;
		sbc_pkg::sbc_lin_e         lin;
	} sbc_mode_s;

	sbc_mode_s state_q;
	sbc_mode_s state_d;

	// Synchronised and filtered views of the inputs
	logic enSync;
	logic txSync;
	logic linSync;
	logic porLowSync;
	logic porHighSync;
	logic hotSync;
	logic uvSync;
	logic uvQual;
	logic wakeQual;
	logic wakeDetectOn;

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	// All pins and comparators cross in before any logic looks at them
	sbc_sync u_syncEn      (.clk(clk), .rst(rst),
		.asyncIn(enablePin),          .syncOut(enSync));
	sbc_sync u_syncTx      (.clk(clk), .rst(rst),
		.asyncIn(txDataPin),          .syncOut(txSync));
	sbc_sync u_syncLin     (.clk(clk), .rst(rst),
		.asyncIn(linBusLow),          .syncOut(linSync));
	sbc_sync u_syncPorLow  (.clk(clk), .rst(rst),
		.asyncIn(supplyBelowPorLow),  .syncOut(porLowSync));
	sbc_sync u_syncPorHigh (.clk(clk), .rst(rst),
		.asyncIn(supplyAbovePorHigh), .syncOut(porHighSync));
	sbc_sync u_syncHot     (.clk(clk), .rst(rst),
		.asyncIn(junctionOvertemp),   .syncOut(hotSync));
	sbc_sync u_syncUv      (.clk(clk), .rst(rst),
		.asyncIn(voutBelowReset),     .syncOut(uvSync));

	// ==========================================================
	// Filters
	// ==========================================================
	// Undervoltage must persist before Reset is forced
	sbc_filter #(.LEN(VOUT_FILT_CYC)) u_uvFilt
	(
		.clk       (clk),
		.rst       (rst),
		.levelIn   (uvSync),
		.qualified (uvQual)
	);

	// Wake detector runs in every mode but Shutdown; Shutdown ignores the bus
	assign wakeDetectOn = (state_q.mode != sbc_pkg::MODE_SHUTDOWN);

	sbc_filter #(.LEN(LIN_WAKE_CYC)) u_wakeFilt
	(
		.clk       (clk),
		.rst       (rst),
		.levelIn   (linSync & wakeDetectOn),
		.qualified (wakeQual)
	);

	// ==========================================================
	// Mode state machine
	// ==========================================================
	always_comb
	begin
		state_d        = state_q;
		state_d.enPrev = enSync;
		state_d.timer  = state_q.timer + 1'b1;

		unique case (state_q.mode)
			sbc_pkg::MODE_SHUTDOWN:
			begin
				// Pending wakes are dropped; the bus is not watched here
				state_d.wakePending = 1'b0;
				if (porHighSync && !hotSync)
				begin
					state_d.mode  = sbc_pkg::MODE_RESET;
					state_d.timer = '0;
				end
			end
			sbc_pkg::MODE_RESET:
			begin
				// Pulse restarts for as long as the regulator is still low
				if (uvSync)
					state_d.timer = '0;
				else if (state_q.timer >= RESET_LAST)
				begin
					state_d.timer = '0;
					if (enSync)
					begin
						state_d.mode        = sbc_pkg::MODE_NORMAL;
						state_d.wakePending = 1'b0;
					end
					else
						state_d.mode = sbc_pkg::MODE_STANDBY;
				end
			end
			sbc_pkg::MODE_NORMAL:
			begin
				// Enable fall starts the sample delay; transmit level picks the target
				unique case (state_q.req)
					REQ_NONE:
						if (state_q.enPrev && !enSync)
						begin
							state_d.req   = REQ_SAMPLE;
							state_d.timer = '0;
						end
					REQ_SAMPLE:
						if (state_q.timer >= SAMPLE_LAST)
						begin
							state_d.req   = txSync ? REQ_STANDBY : REQ_SLEEP;
							state_d.timer = '0;
						end
					REQ_STANDBY, REQ_SLEEP:
						if (state_q.timer >= LP_LAST)
						begin
							state_d.mode = (state_q.req == REQ_STANDBY)
								? sbc_pkg::MODE_STANDBY : sbc_pkg::MODE_SLEEP;
							state_d.req  = REQ_NONE;
						end
				endcase
				// Enable raised again aborts a pending low-power request
				if (enSync && state_q.req != REQ_NONE)
					state_d.req = REQ_NONE;
			end
			sbc_pkg::MODE_STANDBY:
			begin
				// Enable high is the only way out besides the global overrides
				if (enSync)
				begin
					state_d.mode        = sbc_pkg::MODE_NORMAL;
					state_d.wakePending = 1'b0;
				end
			end
			sbc_pkg::MODE_SLEEP:
			begin
				// Either source brings the regulator back by way of Reset
				if (enSync || wakeQual)
				begin
					state_d.mode  = sbc_pkg::MODE_RESET;
					state_d.timer = '0;
				end
			end
			sbc_pkg::MODE_THERMAL:
			begin
				// Cooling always passes through Reset so the host sees a fresh pulse
				if (!hotSync)
				begin
					state_d.mode  = sbc_pkg::MODE_RESET;
					state_d.timer = '0;
				end
			end
			default:
				state_d.mode = sbc_pkg::MODE_SHUTDOWN;
		endcase

		// Wake latched outside Normal and Shutdown; placed after the mode logic so a
		// wake in the cycle of the Normal entry wins over the clear and is not lost
		if (wakeQual && state_q.mode != sbc_pkg::MODE_NORMAL
			&& state_q.mode != sbc_pkg::MODE_SHUTDOWN)
			state_d.wakePending = 1'b1;

		// Undervoltage on the regulator restarts the reset pulse
		if (uvQual && state_q.regOn
			&& (state_d.mode == sbc_pkg::MODE_NORMAL
			|| state_d.mode == sbc_pkg::MODE_STANDBY))
		begin
			state_d.mode  = sbc_pkg::MODE_RESET;
			state_d.req   = REQ_NONE;
			state_d.timer = '0;
		end

		// Over-temperature outranks all but loss of supply
		if (hotSync && state_q.mode != sbc_pkg::MODE_SHUTDOWN)
		begin
			state_d.mode = sbc_pkg::MODE_THERMAL;
			state_d.req  = REQ_NONE;
		end

		// Supply loss wins over everything
		if (porLowSync)
		begin
			state_d.mode = sbc_pkg::MODE_SHUTDOWN;
			state_d.req  = REQ_NONE;
		end

		// Transmitter opens on entry into Normal or when enable rises again in Normal, blocked at enable fall
		// Limitation: no transmit falling-edge gate, so a low level at entry is not held off
		if (state_d.mode != sbc_pkg::MODE_NORMAL || !enSync)
			state_d.txBlocked = 1'b1;
		else if (state_q.mode != sbc_pkg::MODE_NORMAL || state_q.txBlocked)
			state_d.txBlocked = 1'b0;

		// Outputs registered from the next mode
		// Defaults are the safe levels: regulator off, reset held, receive idle high
		state_d.regOn  = 1'b0;
		state_d.rstLow = 1'b1;
		state_d.rxd    = 1'b1;
		state_d.lin    = sbc_pkg::LIN_WAKEUP;
		unique case (state_d.mode)
			sbc_pkg::MODE_SHUTDOWN:
				state_d.lin = sbc_pkg::LIN_OFF;
			sbc_pkg::MODE_RESET:
			begin
				state_d.regOn = 1'b1;
				state_d.lin   = sbc_pkg::LIN_OFF;
				state_d.rxd   = !state_d.wakePending;
			end
			sbc_pkg::MODE_NORMAL:
			begin
				state_d.regOn  = 1'b1;
				state_d.rstLow = 1'b0;
				state_d.lin    = sbc_pkg::LIN_ACTIVE;
				state_d.rxd    = !linSync;
			end
			sbc_pkg::MODE_STANDBY:
			begin
				state_d.regOn  = 1'b1;
				state_d.rstLow = 1'b0;
				state_d.rxd    = !state_d.wakePending;
			end
			sbc_pkg::MODE_SLEEP:
				state_d.rxd = !state_d.wakePending;
			sbc_pkg::MODE_THERMAL:
				state_d.rxd = !state_d.wakePending;
			default:
				state_d.lin = sbc_pkg::LIN_OFF;
		endcase
		state_d.txEn = (state_d.mode == sbc_pkg::MODE_NORMAL) && !state_d.txBlocked
			&& enSync;
	end

	// Reset sets Shutdown with the system reset held low
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q           <= '0;
			state_q.mode      <= sbc_pkg::MODE_SHUTDOWN;
			state_q.rstLow    <= 1'b1;
			state_q.rxd       <= 1'b1;
			state_q.txBlocked <= 1'b1;
			state_q.lin       <= sbc_pkg::LIN_OFF;
		end
		else
			state_q <= state_d;
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Open-drain reset: drives low only, enable low while driving
	// The pin's pull-up gives the high level, so the data bit is tied low
	// and the enable alone carries the reset state
	assign regulatorOn      = state_q.regOn;
	assign systemResetOut_n = 1'b0;
	assign systemResetOe_n  = !state_q.rstLow;
	assign rxDataOut        = state_q.rxd;
	assign linTxEnable      = state_q.txEn;
	assign linSubMode       = state_q.lin;
	assign modeOut          = state_q.mode;

endmodule

// [dv/sbc_mode_ctrl_sva.sv]
`timescale 1ns/1ps

// ==========================================================
// Port checks of the mode controller
// ==========================================================
module sbc_mode_ctrl_sva
(
	input logic               clk,
	input logic               rst,
	input logic               enablePin,
	input logic               supplyBelowPorLow,
	input logic               junctionOvertemp,
	input logic               regulatorOn,
	input logic               systemResetOe_n,
	input logic               rxDataOut,
	input logic               linTxEnable,
	input sbc_pkg::sbc_lin_e  linSubMode,
	input sbc_pkg::sbc_mode_e modeOut
);
	// One domain, so clock and reset are stated once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Outputs per mode; all are registered alongside the mode
	shut_outputs_a: assert property (modeOut == sbc_pkg::MODE_SHUTDOWN |->
		!regulatorOn && !systemResetOe_n && rxDataOut && linSubMode == sbc_pkg::LIN_OFF)
		else $error("shutdown outputs wrong");
	reset_outputs_a: assert property (modeOut == sbc_pkg::MODE_RESET |->
		regulatorOn && !systemResetOe_n && !linTxEnable) else $error("reset outputs wrong");
	normal_outputs_a: assert property (modeOut == sbc_pkg::MODE_NORMAL |->
		regulatorOn && systemResetOe_n && linSubMode == sbc_pkg::LIN_ACTIVE)
		else $error("normal outputs wrong");
	standby_outputs_a: assert property (modeOut == sbc_pkg::MODE_STANDBY |->
		regulatorOn && systemResetOe_n && linSubMode == sbc_pkg::LIN_WAKEUP)
		else $error("standby outputs wrong");
	sleep_outputs_a: assert property (modeOut == sbc_pkg::MODE_SLEEP |->
		!regulatorOn && linSubMode == sbc_pkg::LIN_WAKEUP) else $error("sleep outputs wrong");
	thermal_outputs_a: assert property (modeOut == sbc_pkg::MODE_THERMAL |->
		!regulatorOn && !systemResetOe_n) else $error("thermal outputs wrong");

	// Transitions; the two-flop input sync costs up to three edges
	tx_block_a: assert property ($fell(enablePin) |-> ##[1:4] !linTxEnable)
		else $error("transmitter not blocked");
	sleep_entry_a: assert property ($changed(modeOut) && modeOut == sbc_pkg::MODE_SLEEP |->
		$past(modeOut) == sbc_pkg::MODE_NORMAL) else $error("sleep not from normal");
	shut_exit_a: assert property ($past(modeOut) == sbc_pkg::MODE_SHUTDOWN &&
		modeOut != sbc_pkg::MODE_SHUTDOWN |-> modeOut == sbc_pkg::MODE_RESET)
		else $error("shutdown left wrongly");
	supply_low_a: assert property (supplyBelowPorLow [*4] |->
		modeOut == sbc_pkg::MODE_SHUTDOWN) else $error("no shutdown on low supply");
	thermal_entry_a: assert property ((junctionOvertemp && !supplyBelowPorLow &&
		modeOut != sbc_pkg::MODE_SHUTDOWN) [*4] |-> modeOut == sbc_pkg::MODE_THERMAL)
		else $error("no thermal shutdown");
endmodule

bind sbc_mode_ctrl sbc_mode_ctrl_sva u_sva
(
	.clk(clk),
	.rst(rst),
	.enablePin(enablePin),
	.supplyBelowPorLow(supplyBelowPorLow),
	.junctionOvertemp(junctionOvertemp),
	.regulatorOn(regulatorOn),
	.systemResetOe_n(systemResetOe_n),
	.rxDataOut(rxDataOut),
	.linTxEnable(linTxEnable),
	.linSubMode(linSubMode),
	.modeOut(modeOut)
);

// [dv/sbc_host_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Host microcontroller driving enable and transmit pins
// ==========================================================
module sbc_host_model
(
	input  logic       clk,
	input  logic       rst,
	input  logic       go,
	input  logic [1:0] cmd,
	output logic       enablePin,
	output logic       txDataPin
);
	// Commands: 1 normal, 2 standby, 3 sleep; txd idles high like its pull-up
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			enablePin <= 1'b0;
			txDataPin <= 1'b1;
		end
		else if (go)
		begin
			enablePin <= (cmd == 2'h1);
			txDataPin <= (cmd != 2'h3);
		end
	end
endmodule

// [dv/test_sbc_operating_mode_controller.sv]
`timescale 1ns/1ps

module test_sbc_operating_mode_controller;
	// Short counts keep the run brief
	localparam int unsigned ST = 8;
	localparam int unsigned LP = 12;
	localparam int unsigned VF = 6;
	localparam int unsigned LW = 10;
	localparam int unsigned RE = 40;

	logic clk, rst, go, lin, sLow, sHigh, hot, vLow;
	logic [1:0] cmd;
	logic enablePin, txDataPin, regulatorOn, resetOe_n, resetOut_n, rxDataOut;
	sbc_pkg::sbc_mode_e modeOut;
	int numErrors, cmpCount, cyc, seed, k;

	// ==========================================================
	// Design, host and clock
	// ==========================================================
	sbc_mode_ctrl #(.SAMPLE_TXD_CYC(ST), .LP_MODE_CYC(LP), .VOUT_FILT_CYC(VF),
		.LIN_WAKE_CYC(LW), .RESET_EXT_CYC(RE)) DUT (.clk(clk), .rst(rst),
		.enablePin(enablePin), .txDataPin(txDataPin), .linBusLow(lin),
		.supplyBelowPorLow(sLow), .supplyAbovePorHigh(sHigh), .junctionOvertemp(hot),
		.voutBelowReset(vLow), .regulatorOn(regulatorOn), .systemResetOut_n(resetOut_n),
		.systemResetOe_n(resetOe_n), .rxDataOut(rxDataOut), .linTxEnable(),
		.linSubMode(), .modeOut(modeOut));
	sbc_host_model host_i (.clk(clk), .rst(rst), .go(go), .cmd(cmd),
		.enablePin(enablePin), .txDataPin(txDataPin));

	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			numErrors++;
			printVerdict();
		end
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	task chk(input logic [2:0] s, input logic [2:0] e);
		cmpCount++;
		if (s !== e)
		begin
			numErrors++;
			$display("wrong value at %0t: saw %0d expected %0d", $time, s, e);
		end
	endtask

	function automatic logic [2:0] exitMode(input logic b, input logic lp);
		if (lp)
			return b ? sbc_pkg::MODE_STANDBY : sbc_pkg::MODE_SLEEP;
		return b ? sbc_pkg::MODE_NORMAL : sbc_pkg::MODE_STANDBY;
	endfunction

	// Samples on the falling edge, away from the design's updates
	task waitMode(input logic [2:0] m, input int lim);
		int i;
		i = 0;
		@(negedge clk);
		while (modeOut !== m && i < lim)
		begin
			@(negedge clk);
			i++;
		end
		chk(modeOut, m);
	endtask

	task host(input logic [1:0] c);
		@(posedge clk);
		go <= 1'b1;
		cmd <= c;
		@(posedge clk);
		go <= 1'b0;
	endtask

	task pulse(input int n);
		@(posedge clk);
		lin <= 1'b1;
		repeat (n) @(posedge clk);
		lin <= 1'b0;
	endtask

	task printVerdict;
		if (numErrors == 0 && cmpCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial
	begin
		{rst, seed} = {1'b1, 32'd93};
		{go, cmd, lin, sLow, sHigh, hot, vLow} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		waitMode(sbc_pkg::MODE_SHUTDOWN, 0);
		chk(3'(regulatorOn), 3'h0);
		// Power-up with enable low, then high
		for (k = 0; k < 2; k++)
		begin
			host(k ? 2'h1 : 2'h2);
			{sLow, sHigh} <= 2'b01;
			waitMode(sbc_pkg::MODE_RESET, 8);
			chk(3'(regulatorOn), 3'h1);
			waitMode(exitMode(k, 0), RE + 8);
			chk(3'(resetOe_n), 3'h1);
			if (k == 0)
			begin
				host(2'h1);
				waitMode(sbc_pkg::MODE_NORMAL, 8);
				@(posedge clk);
				{sLow, sHigh} <= 2'b10;
				waitMode(sbc_pkg::MODE_SHUTDOWN, 6);
			end
		end
		// Sleep and standby round trips
		for (k = 0; k < 4; k++)
		begin
			host(k[0] ? 2'h2 : 2'h3);
			repeat (ST) @(negedge clk);
			chk(modeOut, sbc_pkg::MODE_NORMAL);
			waitMode(exitMode(k[0], 1), LP + 8);
			chk(3'(regulatorOn), 3'(k[0]));
			if (k == 0)
			begin
				pulse(1 + $unsigned($random(seed)) % 4);
				repeat (LW) @(negedge clk);
				chk(modeOut, sbc_pkg::MODE_SLEEP);
				pulse(LW + 4);
				waitMode(sbc_pkg::MODE_RESET, 8);
				chk(3'(rxDataOut), 3'h0);
				waitMode(sbc_pkg::MODE_STANDBY, RE + 8);
				chk(3'(rxDataOut), 3'h0);
			end
			host(2'h1);
			if (k == 2)
				waitMode(sbc_pkg::MODE_RESET, 8);
			waitMode(sbc_pkg::MODE_NORMAL, RE + 8);
			chk(3'(rxDataOut), 3'h1);
		end
		// Regulator undervoltage, then over-temperature
		// Inputs move on the rising edge, after the falling-edge checks
		@(posedge clk);
		vLow <= 1'b1;
		waitMode(sbc_pkg::MODE_RESET, VF + 6);
		@(posedge clk);
		vLow <= 1'b0;
		waitMode(sbc_pkg::MODE_NORMAL, RE + 8);
		@(posedge clk);
		hot <= 1'b1;
		waitMode(sbc_pkg::MODE_THERMAL, 6);
		chk(3'(resetOe_n), 3'h0);
		chk(3'(resetOut_n), 3'h0);
		@(posedge clk);
		hot <= 1'b0;
		waitMode(sbc_pkg::MODE_RESET, 6);
		printVerdict();
	end
endmodule
